// ### src/tsf_top.sv
// timer status flags with a classic wishbone register slave
//
// How it works
// - overrun flag sets only in input capture mode; writing zero clears it
// - capture while channel flag still set raises that channel's overrun flag
// - break flag sets while the break input is active
// - break flag clear only sticks once break input is inactive again
// - trigger flag sets on active trigger edge outside gated mode
// - in gated mode both trigger edges set trigger flag; software clears
// - commutation event sets commutation flag; software clears it
// - output mode, not center aligned: counter equal compare sets channel flag
// - compare above auto reload: flag on overflow, or on underflow when counting down edge aligned
// - input mode: capture edge sets the channel flag
// - input mode: software clear or capture register read clears flag
// - channels 2..4 at bits 2..4, channels 5,6 at 16,17, same behaviour
// - overrun flags of channels 2..4 at bits 10..12, same behaviour
// - repetition counter update sets update flag unless updates disabled
// - software update generation sets update flag when source select is 0
// - slave trigger counter reinit sets update flag when source select is 0
// - reserved status bits always read zero
// - reset clears the whole status register
// - interrupt requested while a flag and its enable bit are both set
// - slave mode code 101 is gated mode
//
// The Wishbone interface to the registers was decided locally.
`timescale 1ns/1ps
module tsf_top #(
  parameter int CNT_W  = 16,
  parameter int ADDR_W = 8
) (
  // clock and reset
  input  wire logic                                  clk,
  input  wire logic                                  rst_n,
  // wishbone slave
  input  wire logic                                  wb_cyc_i,
  input  wire logic                                  wb_stb_i,
  input  wire logic                                  wb_we_i,
  input  wire logic [ADDR_W-1:0]                     wb_adr_i,
  input  wire logic [3:0]                            wb_sel_i,
  input  wire logic [31:0]                           wb_dat_i,
  output logic      [31:0]                           wb_dat_o,
  output logic                                       wb_ack_o,
  // pins
  input  wire logic                                  break_input,
  input  wire logic                                  trigger_input,
  // slave controller
  input  wire logic [2:0]                            slave_mode,
  input  wire logic                                  slave_reinit,
  // commutation
  input  wire logic                                  commutation_event,
  // channels
  input  wire logic [tsf_pkg::NUM_CHAN-1:0]          chan_input_mode,
  input  wire logic [tsf_pkg::NUM_CHAN-1:0]          capture_event,
  input  wire logic [tsf_pkg::NUM_CHAN-1:0]          capture_read,
  input  wire logic [tsf_pkg::NUM_CHAN-1:0][CNT_W-1:0] chan_compare_value,
  // counter
  input  wire logic [CNT_W-1:0]                      counter_value,
  input  wire logic [CNT_W-1:0]                      auto_reload_value,
  input  wire logic                                  counter_step,
  input  wire logic                                  counter_overflow,
  input  wire logic                                  counter_underflow,
  input  wire logic                                  count_down,
  input  wire logic [1:0]                            center_align_select,
  // update control
  input  wire logic                                  update_disable,
  input  wire logic                                  update_request_source,
  input  wire logic                                  repetition_update,
  input  wire logic                                  update_generate,
  // interrupt
  output logic                                       irq
);

  localparam int NC = tsf_pkg::NUM_CHAN;
  localparam int NO = tsf_pkg::NUM_OVR;

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers

  logic brk_meta_reg;
  logic brk_sync_reg;
  logic trg_meta_reg;
  logic trg_sync_reg;
  logic trg_prev_reg;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      brk_meta_reg <= 1'h0;
      brk_sync_reg <= 1'h0;
    end else begin
      brk_meta_reg <= break_input;
      brk_sync_reg <= brk_meta_reg;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      trg_meta_reg <= 1'h0;
      trg_sync_reg <= 1'h0;
      trg_prev_reg <= 1'h0;
    end else begin
      trg_meta_reg <= trigger_input;
      trg_sync_reg <= trg_meta_reg;
      trg_prev_reg <= trg_sync_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // bus decode

  logic        req;
  logic        wr_sts;
  logic        wr_ien;
  logic [31:0] wr_clr;
  logic [31:0] lane_mask;

  assign req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wr_sts = req & wb_we_i & (wb_adr_i == tsf_pkg::STS_OFFSET);
  assign wr_ien = req & wb_we_i & (wb_adr_i == tsf_pkg::IEN_OFFSET);
  assign lane_mask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
  // only bits written as zero in an enabled lane clear
  assign wr_clr = wr_sts ? (lane_mask & ~wb_dat_i) : 32'h0000_0000;

  ////////////////////////////////////////////////////////////////////////////
  // channel flags

  logic [NC-1:0] cc_flag_reg;
  logic [NC-1:0] cc_set;
  logic [NC-1:0] cc_clr;
  logic [NO-1:0] ovr_flag_reg;
  logic [NO-1:0] ovr_set;
  logic [NO-1:0] ovr_clr;
  logic          center;

  assign center = center_align_select != 2'h0;

  genvar gi;
  generate
    for (gi = 0; gi < NC; gi++) begin : g_chan
      localparam int POS = (gi < 4) ? tsf_pkg::CC1_BIT + gi : tsf_pkg::CC5_BIT + gi - 4;
      logic above;
      logic wrap;
      logic match;
      assign above = chan_compare_value[gi] > auto_reload_value;
      // up/down counting reports the overflow only
      assign wrap = (count_down & ~center) ? counter_underflow : counter_overflow;
      assign match = above ? wrap
                   : (counter_step & ~center & (counter_value == chan_compare_value[gi]));
      assign cc_set[gi] = chan_input_mode[gi] ? capture_event[gi] : match;
      assign cc_clr[gi] = wr_clr[POS] | (chan_input_mode[gi] & capture_read[gi]);
      // every channel checks its own capture set path
      AST_CC_CAP: assert property (@(posedge clk) disable iff (!rst_n)
          chan_input_mode[gi] && capture_event[gi] |=> cc_flag_reg[gi])
        else $error("capture did not set channel flag");
      if (gi < NO) begin : g_ovr
        // overrun looks at the flag before this cycle's set
        assign ovr_set[gi] = chan_input_mode[gi] & capture_event[gi] & cc_flag_reg[gi];
        assign ovr_clr[gi] = wr_clr[tsf_pkg::OVR1_BIT + gi];
        AST_OVR_CHAN: assert property (@(posedge clk) disable iff (!rst_n)
            chan_input_mode[gi] && capture_event[gi] && cc_flag_reg[gi] |=> ovr_flag_reg[gi])
          else $error("overrun flag of a channel not set");
      end
    end
  endgenerate

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cc_flag_reg <= '0;
    end else begin
      cc_flag_reg <= (cc_flag_reg & ~cc_clr) | cc_set;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ovr_flag_reg <= '0;
    end else begin
      ovr_flag_reg <= (ovr_flag_reg & ~ovr_clr) | ovr_set;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // break, trigger, commutation and update flags

  logic brk_flag_reg;
  logic trg_flag_reg;
  logic com_flag_reg;
  logic upd_flag_reg;
  logic gated;
  logic trg_set;
  logic upd_set;

  assign gated = slave_mode == tsf_pkg::SLAVE_GATED;
  assign trg_set = gated ? (trg_sync_reg ^ trg_prev_reg)
                         : (trg_sync_reg & ~trg_prev_reg);
  assign upd_set = ~update_disable & (repetition_update
                 | (~update_request_source & (update_generate | slave_reinit)));

  // an active break input re-sets the flag every cycle, so a clear cannot stick
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      brk_flag_reg <= 1'h0;
    end else if (brk_sync_reg) begin
      brk_flag_reg <= 1'h1;
    end else if (wr_clr[tsf_pkg::BRK_BIT]) begin
      brk_flag_reg <= 1'h0;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      trg_flag_reg <= 1'h0;
    end else if (trg_set) begin
      trg_flag_reg <= 1'h1;
    end else if (wr_clr[tsf_pkg::TRG_BIT]) begin
      trg_flag_reg <= 1'h0;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      com_flag_reg <= 1'h0;
    end else if (commutation_event) begin
      com_flag_reg <= 1'h1;
    end else if (wr_clr[tsf_pkg::COM_BIT]) begin
      com_flag_reg <= 1'h0;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      upd_flag_reg <= 1'h0;
    end else if (upd_set) begin
      upd_flag_reg <= 1'h1;
    end else if (wr_clr[tsf_pkg::UPD_BIT]) begin
      upd_flag_reg <= 1'h0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // status view, enable register, read data, interrupt

  logic [31:0] sts_view;
  logic [31:0] ien_reg;
  logic [31:0] rd_data;

  always_comb begin
    sts_view = tsf_pkg::STS_RESET;
    sts_view[tsf_pkg::UPD_BIT] = upd_flag_reg;
    sts_view[tsf_pkg::CC1_BIT +: 4] = cc_flag_reg[3:0];
    sts_view[tsf_pkg::COM_BIT] = com_flag_reg;
    sts_view[tsf_pkg::TRG_BIT] = trg_flag_reg;
    sts_view[tsf_pkg::BRK_BIT] = brk_flag_reg;
    sts_view[tsf_pkg::OVR1_BIT +: NO] = ovr_flag_reg;
    sts_view[tsf_pkg::CC5_BIT +: 2] = cc_flag_reg[5:4];
    sts_view = sts_view & tsf_pkg::STS_MASK;
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ien_reg <= tsf_pkg::IEN_RESET;
    end else if (wr_ien) begin
      ien_reg <= (ien_reg & ~lane_mask) | (wb_dat_i & lane_mask & tsf_pkg::STS_MASK);
    end
  end

  always_comb begin
    case (wb_adr_i)
      tsf_pkg::STS_OFFSET: rd_data = sts_view;
      tsf_pkg::IEN_OFFSET: rd_data = ien_reg;
      default:             rd_data = 32'h0000_0000;
    endcase
  end

  // unmapped addresses are acked with zero data; one wait state keeps ack registered
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wb_ack_o <= 1'h0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= req;
      wb_dat_o <= (req & ~wb_we_i) ? rd_data : 32'h0000_0000;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      irq <= 1'h0;
    end else begin
      irq <= |(sts_view & ien_reg);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // assertions

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  AST_BRK_SET: assert property (brk_sync_reg |=> brk_flag_reg)
    else $error("break flag not set by active break");
  AST_BRK_HOLD: assert property (brk_sync_reg && wr_clr[tsf_pkg::BRK_BIT] |=> brk_flag_reg[*1])
    else $error("break flag cleared while break active");
  AST_TRG_EDGE: assert property (!gated && $rose(trg_sync_reg) |=> trg_flag_reg)
    else $error("trigger flag missed rising edge");
  AST_TRG_GATED: assert property (gated && $fell(trg_sync_reg) |=> trg_flag_reg)
    else $error("trigger flag missed falling edge in gated mode");
  AST_COM_WINS: assert property (commutation_event && wr_clr[tsf_pkg::COM_BIT] |=> com_flag_reg)
    else $error("commutation flag lost to clear");
  AST_CMP_MATCH: assert property (!chan_input_mode[0] && counter_step && !center
      && chan_compare_value[0] <= auto_reload_value && counter_value == chan_compare_value[0]
      |=> cc_flag_reg[0])
    else $error("compare match did not set channel flag");
  // center aligned counting gives no compare match flag
  AST_CMP_CENTER: assert property (!chan_input_mode[0] && center && !cc_flag_reg[0]
      && chan_compare_value[0] <= auto_reload_value |=> !cc_flag_reg[0])
    else $error("channel flag set in center aligned counting");
  AST_CMP_WRAP: assert property (!chan_input_mode[0] && chan_compare_value[0] > auto_reload_value
      && !count_down && counter_overflow |=> cc_flag_reg[0])
    else $error("overflow did not set channel flag");
  AST_WRAP_DOWN: assert property (!chan_input_mode[0] && chan_compare_value[0] > auto_reload_value
      && count_down && !center && counter_underflow |=> cc_flag_reg[0])
    else $error("underflow did not set channel flag");
  AST_WRAP_CENTER: assert property (!chan_input_mode[0] && chan_compare_value[0] > auto_reload_value
      && center && counter_overflow |=> cc_flag_reg[0])
    else $error("center aligned overflow did not set channel flag");
  AST_CAP_READ: assert property (chan_input_mode[0] && capture_read[0] && !capture_event[0]
      |=> !cc_flag_reg[0])
    else $error("capture read did not clear channel flag");
  AST_OVR_SET: assert property (chan_input_mode[1] && capture_event[1] && cc_flag_reg[1]
      |=> ovr_flag_reg[1] && cc_flag_reg[1])
    else $error("overrun flag not set");
  AST_OVR_OUT: assert property (!chan_input_mode[0] && !ovr_flag_reg[0] |=> !ovr_flag_reg[0])
    else $error("overrun set outside input mode");
  AST_UPD_SW: assert property (!update_disable && !update_request_source && update_generate
      |=> upd_flag_reg)
    else $error("update generation did not set update flag");
  AST_UPD_REP: assert property (!update_disable && repetition_update |=> upd_flag_reg)
    else $error("repetition update did not set update flag");
  AST_UPD_TRG: assert property (!update_disable && !update_request_source && slave_reinit
      |=> upd_flag_reg)
    else $error("slave reinit did not set update flag");
  AST_COM_CLR: assert property (wr_clr[tsf_pkg::COM_BIT] && !commutation_event |=> !com_flag_reg)
    else $error("commutation flag not cleared");
  AST_BRK_IDLE: assert property (!brk_sync_reg && !brk_flag_reg |=> !brk_flag_reg)
    else $error("break flag set without break");
  AST_BRK_CLR: assert property (wr_clr[tsf_pkg::BRK_BIT] && !brk_sync_reg |=> !brk_flag_reg)
    else $error("break flag clear lost after break ended");
  AST_TRG_ANY: assert property (gated && $rose(trg_sync_reg) |=> trg_flag_reg)
    else $error("trigger flag missed rising edge in gated mode");
  AST_TRG_CLR: assert property (wr_clr[tsf_pkg::TRG_BIT] && $stable(trg_sync_reg) |=> !trg_flag_reg)
    else $error("trigger flag not cleared");
  AST_OVR_CLR: assert property (wr_clr[tsf_pkg::OVR1_BIT] && !(chan_input_mode[0] && capture_event[0])
      |=> !ovr_flag_reg[0])
    else $error("overrun flag not cleared");
  // a one in an enabled lane must leave a set flag alone
  AST_KEEP_ONE: assert property (wr_sts && wb_sel_i[0] && wb_dat_i[tsf_pkg::CC1_BIT] && cc_flag_reg[0]
      && !(chan_input_mode[0] && capture_read[0]) |=> cc_flag_reg[0])
    else $error("write of one cleared channel flag");
  AST_IRQ_OFF: assert property (!(|(sts_view & ien_reg)) |=> !irq)
    else $error("interrupt raised with nothing enabled and pending");
  AST_UPD_DIS: assert property (update_disable && !upd_flag_reg |=> !upd_flag_reg)
    else $error("update flag set while updates disabled");
  AST_RSV: assert property (wb_ack_o |-> (wb_dat_o & ~tsf_pkg::STS_MASK) == 32'h0000_0000)
    else $error("reserved bits read non zero");
  AST_IRQ: assert property (|(sts_view & ien_reg) |=> irq)
    else $error("interrupt not raised");
  AST_RESET: assert property (@(posedge clk) disable iff (1'b0) !rst_n |=> sts_view == 32'h0000_0000)
    else $error("status not zero after reset");

  COV_CAPTURE_OVR: cover property (capture_event[0] && cc_flag_reg[0] && chan_input_mode[0] ##1 ovr_flag_reg[0]);
  COV_BRK_CLEAR: cover property (brk_flag_reg && !brk_sync_reg && wr_clr[tsf_pkg::BRK_BIT] ##1 !brk_flag_reg);
  COV_GATED_TRG: cover property (gated && $fell(trg_sync_reg) ##1 trg_flag_reg);
  COV_IRQ: cover property ($rose(irq));
  COV_UPD_SW: cover property (update_generate && !update_disable ##1 upd_flag_reg);

endmodule

// ### src/tsf_pkg.sv
// shared constants of the timer status flag block
package tsf_pkg;
  // register byte offsets
  localparam logic [7:0]  IEN_OFFSET   = 8'h0C;
  localparam logic [7:0]  STS_OFFSET   = 8'h10;
  // reset values
  localparam logic [31:0] STS_RESET    = 32'h0000_0000;
  localparam logic [31:0] IEN_RESET    = 32'h0000_0000;
  // status field positions
  localparam int          UPD_BIT      = 0;
  localparam int          CC1_BIT      = 1;
  localparam int          COM_BIT      = 5;
  localparam int          TRG_BIT      = 6;
  localparam int          BRK_BIT      = 7;
  localparam int          OVR1_BIT     = 9;
  localparam int          CC5_BIT      = 16;
  // writable and defined bits; the rest read zero
  localparam logic [31:0] STS_MASK     = 32'h0003_1EFF;
  // slave mode code of gated mode
  localparam logic [2:0]  SLAVE_GATED  = 3'h5;
  // channel counts
  localparam int          NUM_CHAN     = 6;
  localparam int          NUM_OVR      = 4;
endpackage

// ### test/tsf_testbench.sv
// self-checking bench for the timer status flag block
`timescale 1ns/1ps
module testbench;
  logic        clk       = 1'b0;
  logic        rst_n     = 1'b0;
  logic        cyc       = 1'b0;
  logic        stb       = 1'b0;
  logic        we        = 1'b0;
  logic [7:0]  adr       = 8'h00;
  logic [3:0]  sel       = 4'h0;
  logic [31:0] wdat      = 32'h0;
  logic [31:0] rdat;
  logic [31:0] ien       = 32'h0;
  logic [31:0] dat_o;
  logic        ack;
  logic        irq;
  // pulses: comm, rep, gen, reinit, step, ovf, unf, capture, read
  logic [8:0]  ev        = 9'h000;
  // levels: brk, trg, gated, dis, src, cen, down, input mode
  logic [7:0]  cfg       = 8'h00;
  logic [15:0] arl       = 16'h00FF;
  int          n_errors  = 0;
  int          tests_run = 0;

  always #25 clk = ~clk;

  tsf_top u_dut (
    .clk(clk), .rst_n(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack),
    .break_input(cfg[7]), .trigger_input(cfg[6]), .slave_mode(cfg[5] ? 3'h5 : 3'h0),
    .slave_reinit(ev[3]), .commutation_event(ev[0]), .chan_input_mode({6{cfg[0]}}),
    .capture_event({6{ev[7]}}), .capture_read({6{ev[8]}}), .chan_compare_value({6{16'h0010}}),
    .counter_value(16'h0010), .auto_reload_value(arl), .counter_step(ev[4]),
    .counter_overflow(ev[5]), .counter_underflow(ev[6]), .count_down(cfg[1]),
    .center_align_select({1'b0, cfg[2]}), .update_disable(cfg[4]), .update_request_source(cfg[3]),
    .repetition_update(ev[1]), .update_generate(ev[2]), .irq(irq));

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD at %0t: word %h, expected %h", $time, got, exp);
    end
  endtask

  task automatic chk1(input logic got, input logic exp);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD at %0t: irq %b, expected %b", $time, got, exp);
    end
  endtask

  // no fixed wait: the slave answers when it answers; a hang is left to the watchdog
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= s;
    do begin
      @(posedge clk);
    end while (ack !== 1'b1);
    rdat = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    // ack stands one cycle only
    @(posedge clk);
    if (ack !== 1'b0) begin
      n_errors++;
      $display("BAD at %0t: acknowledge stood a second cycle", $time);
    end
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    wb(1'b0, a, 32'h0, 4'hF);
    chk32(rdat, exp);
  endtask

  // set levels, fire pulses, read status and irq, then clear unless kept
  task automatic run(input logic [8:0] v, input logic [7:0] c, input logic [15:0] r,
                     input logic [31:0] exp, input logic keep);
    @(posedge clk);
    cfg <= c;
    arl <= r;
    @(posedge clk);
    ev <= v;
    @(posedge clk);
    ev <= 9'h000;
    repeat (4) @(posedge clk);
    rd(8'h10, exp);
    chk1(irq, |(exp & ien));
    if (!keep) wb(1'b1, 8'h10, 32'h0, 4'hF);
  endtask

  task automatic close_out();
    $display("errors %0d, checks %0d", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20000) @(posedge clk);
    n_errors++;
    $display("BAD at %0t: watchdog expired", $time);
    close_out();
  end

  initial begin
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    rd(8'h10, 32'h0);
    rd(8'h0C, 32'h0);
    wb(1'b1, 8'h10, 32'hFFFF_FFFF, 4'hF);
    rd(8'h10, 32'h0);
    wb(1'b1, 8'h40, 32'hFFFF_FFFF, 4'hF);
    rd(8'h40, 32'h0);
    rd(8'h0C, 32'h0);
    run(9'h001, 8'h00, 16'h00FF, 32'h0000_0020, 0);
    run(9'h002, 8'h00, 16'h00FF, 32'h0000_0001, 0);
    run(9'h002, 8'h10, 16'h00FF, 32'h0000_0000, 0);
    run(9'h004, 8'h00, 16'h00FF, 32'h0000_0001, 0);
    run(9'h004, 8'h08, 16'h00FF, 32'h0000_0000, 0);
    run(9'h004, 8'h10, 16'h00FF, 32'h0000_0000, 0);
    run(9'h008, 8'h00, 16'h00FF, 32'h0000_0001, 0);
    run(9'h008, 8'h08, 16'h00FF, 32'h0000_0000, 0);
    run(9'h010, 8'h00, 16'h00FF, 32'h0003_001E, 0);
    run(9'h010, 8'h04, 16'h00FF, 32'h0000_0000, 0);
    run(9'h020, 8'h00, 16'h0008, 32'h0003_001E, 0);
    run(9'h040, 8'h02, 16'h0008, 32'h0003_001E, 0);
    run(9'h020, 8'h02, 16'h0008, 32'h0000_0000, 0);
    run(9'h020, 8'h00, 16'h00FF, 32'h0000_0000, 0);
    run(9'h020, 8'h06, 16'h0008, 32'h0003_001E, 0);
    run(9'h040, 8'h06, 16'h0008, 32'h0000_0000, 0);
    run(9'h080, 8'h01, 16'h00FF, 32'h0003_001E, 1);
    run(9'h080, 8'h01, 16'h00FF, 32'h0003_1E1E, 1);
    wb(1'b1, 8'h10, 32'hFFFF_FDFF, 4'hF);
    rd(8'h10, 32'h0003_1C1E);
    run(9'h100, 8'h01, 16'h00FF, 32'h0000_1C00, 0);
    run(9'h000, 8'h40, 16'h00FF, 32'h0000_0040, 0);
    run(9'h000, 8'h00, 16'h00FF, 32'h0000_0000, 0);
    run(9'h000, 8'h60, 16'h00FF, 32'h0000_0040, 0);
    run(9'h000, 8'h20, 16'h00FF, 32'h0000_0040, 0);
    run(9'h000, 8'h80, 16'h00FF, 32'h0000_0080, 0);
    run(9'h000, 8'h80, 16'h00FF, 32'h0000_0080, 0);
    run(9'h000, 8'h00, 16'h00FF, 32'h0000_0080, 0);
    run(9'h000, 8'h00, 16'h00FF, 32'h0000_0000, 0);
    // hardware set lands on the very edge that the clear is applied
    fork
      wb(1'b1, 8'h10, 32'h0, 4'hF);
      begin
        @(posedge clk);
        ev <= 9'h001;
        @(posedge clk);
        ev <= 9'h000;
      end
    join
    rd(8'h10, 32'h0000_0020);
    wb(1'b1, 8'h10, 32'h0, 4'hE);
    rd(8'h10, 32'h0000_0020);
    wb(1'b1, 8'h0C, 32'h0000_0020, 4'hF);
    ien = 32'h0000_0020;
    rd(8'h0C, 32'h0000_0020);
    run(9'h001, 8'h00, 16'h00FF, 32'h0000_0020, 1);
    wb(1'b1, 8'h0C, 32'h0, 4'hF);
    ien = 32'h0;
    rd(8'h0C, 32'h0);
    chk1(irq, 1'b0);
    wb(1'b1, 8'h10, 32'h0, 4'h1);
    rd(8'h10, 32'h0);
    close_out();
  end
endmodule
